// ===== rtl/fwc_regs.vh
// register indices, field positions and codes of the flash write control
`ifndef FWC_REGS_VH
`define FWC_REGS_VH

// register indices; byte address is four times the index
`define FWC_IDX_STAT 20'h80000
`define FWC_IDX_CMDH 20'h80002
`define FWC_IDX_SECL 20'h80004
`define FWC_IDX_SECH 20'h80006
`define FWC_IDX_D0L 20'h80008
`define FWC_IDX_D0H 20'h8000A
`define FWC_IDX_D1L 20'h8000C
`define FWC_IDX_D1H 20'h8000E
`define FWC_IDX_ADRL 20'h80010
`define FWC_IDX_ADRH 20'h80012
`define FWC_IDX_FAULT 20'h80014

// command register fields
`define FWC_START_BIT 15
`define FWC_PAUSE_BIT 14
`define FWC_SWP_BIT 13
`define FWC_DWP_BIT 12
`define FWC_WIPE_BIT 11
`define FWC_PROT_BIT 8
`define FWC_CMD_MASK 16'hF900

// status and fault fields
`define FWC_LOCK_BIT 4
`define FWC_BUSY_BIT 1
`define FWC_ERR_BIT 0
`define FWC_SEQ_BIT 1

`define FWC_RESET_16 16'h0000
`define FWC_INVALID_DATA 16'hFFFF
`define FWC_TRAP_CODE 8'h9B

// protection register window
`define FWC_PROT_LO 32'h0008DFB0
`define FWC_PROT_HI 32'h0008DFBF

// fill values of the two erase phases
`define FWC_FILL_PRE 8'h00
`define FWC_FILL_ERASE 8'hFF

// operation codes
`define FWC_OP_NONE 3'h0
`define FWC_OP_SWP 3'h1
`define FWC_OP_DWP 3'h2
`define FWC_OP_WIPE 3'h3
`define FWC_OP_PROT 3'h4

// bus answers
`define FWC_RESP_OKAY 2'h0
`define FWC_RESP_SLVERR 2'h2

`endif

// ===== rtl/fwc_sync.v
// two-stage synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module fwc_sync #(
    parameter W = 1
) (
    input wire clk,
    input wire rst,
    input wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta_ff;
    reg [W-1:0] sync_ff;

    always @(posedge clk) begin
        if (rst) begin
            meta_ff <= {W{1'b0}};
            sync_ff <= {W{1'b0}};
        end else begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end

    assign q = sync_ff;
endmodule
`default_nettype wire

// ===== rtl/fwc_axil.v
// axi4-lite slave front end producing register strobes
`timescale 1ns/1ns
`default_nettype none
`include "fwc_regs.vh"
module fwc_axil #(
    parameter AW = 22
) (
    input wire clk,
    input wire rst,
    // write channels
    input wire [AW-1:0] awaddr,
    input wire awvalid,
    output wire awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output wire wready,
    output wire [1:0] bresp,
    output wire bvalid,
    input wire bready,
    // read channels
    input wire [AW-1:0] araddr,
    input wire arvalid,
    output wire arready,
    output wire [31:0] rdata,
    output wire [1:0] rresp,
    output wire rvalid,
    input wire rready,
    // register side
    output wire wr_stb,
    output wire [AW-1:0] wr_addr,
    output wire [31:0] wr_data,
    output wire [3:0] wr_strb,
    input wire wr_hit,
    output wire rd_stb,
    output wire [AW-1:0] rd_addr,
    input wire [15:0] rd_data,
    input wire rd_hit
);
    reg aw_full_ff;
    reg w_full_ff;
    reg [AW-1:0] awaddr_ff;
    reg [31:0] wdata_ff;
    reg [3:0] wstrb_ff;
    reg bvalid_ff;
    reg [1:0] bresp_ff;
    reg rvalid_ff;
    reg [1:0] rresp_ff;
    reg [15:0] rdata_ff;

    // address and data are taken in either order, response after both
    assign awready = !aw_full_ff && !bvalid_ff;
    assign wready = !w_full_ff && !bvalid_ff;
    assign wr_stb = aw_full_ff && w_full_ff && !bvalid_ff;
    assign wr_addr = awaddr_ff;
    assign wr_data = wdata_ff;
    assign wr_strb = wstrb_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;

    assign arready = !rvalid_ff;
    assign rd_stb = arvalid && !rvalid_ff;
    assign rd_addr = araddr;
    assign rvalid = rvalid_ff;
    assign rresp = rresp_ff;
    assign rdata = {16'h0000, rdata_ff};

    always @(posedge clk) begin
        if (rst) begin
            aw_full_ff <= 1'b0;
            w_full_ff <= 1'b0;
            awaddr_ff <= {AW{1'b0}};
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `FWC_RESP_OKAY;
            rvalid_ff <= 1'b0;
            rresp_ff <= `FWC_RESP_OKAY;
            rdata_ff <= `FWC_RESET_16;
        end else begin
            if (awvalid && awready) begin
                aw_full_ff <= 1'b1;
                awaddr_ff <= awaddr;
            end
            if (wvalid && wready) begin
                w_full_ff <= 1'b1;
                wdata_ff <= wdata;
                wstrb_ff <= wstrb;
            end
            if (wr_stb) begin
                aw_full_ff <= 1'b0;
                w_full_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_hit ? `FWC_RESP_OKAY : `FWC_RESP_SLVERR;
            end else if (bvalid_ff && bready) begin
                bvalid_ff <= 1'b0;
            end
            if (rd_stb) begin
                rvalid_ff <= 1'b1;
                rdata_ff <= rd_hit ? rd_data : `FWC_RESET_16;
                rresp_ff <= rd_hit ? `FWC_RESP_OKAY : `FWC_RESP_SLVERR;
            end else if (rvalid_ff && rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ===== rtl/fwc_top.v
// flash write operation select, start, suspend and resume control
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "fwc_regs.vh"
module fwc_top #(
    parameter AW = 22,
    parameter [31:0] TEST_LO = 32'h00000000,
    parameter [31:0] TEST_HI = 32'h00001FFF
) (
    // clock and reset
    input wire CLOCK,
    input wire SYS_RST,
    // axi4-lite register bus
    input wire [AW-1:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output wire S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output wire S_AXI_WREADY,
    output wire [1:0] S_AXI_BRESP,
    output wire S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [AW-1:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output wire S_AXI_ARREADY,
    output wire [31:0] S_AXI_RDATA,
    output wire [1:0] S_AXI_RRESP,
    output wire S_AXI_RVALID,
    input wire S_AXI_RREADY,
    // flash array engine
    output wire ARR_GO,
    output wire ARR_SUSPEND,
    output wire ARR_RESUME,
    output wire [2:0] ARR_OP,
    output wire [31:0] ARR_ADDR,
    output wire [63:0] ARR_WDATA,
    output wire [7:0] ARR_FILL,
    output wire [31:0] ARR_SECTORS,
    input wire [63:0] ARR_OLD,
    input wire ARR_DONE,
    // bank access and mode
    input wire BOOT_MODE,
    input wire BANK_RD,
    output wire BANK_TRAP,
    output wire [7:0] TRAP_NUM,
    output wire BANK_WR_EN,
    output wire TEST_SECTOR_VISIBLE
);
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_PRE = 3'd1;
    localparam [2:0] ST_RUN = 3'd2;
    localparam [2:0] ST_PSUSP = 3'd3;
    localparam [2:0] ST_ESUSP = 3'd4;
    localparam [2:0] ST_NEST = 3'd5;

    wire wr_stb;
    wire rd_stb;
    wire [AW-1:0] wr_addr;
    wire [AW-1:0] rd_addr;
    wire [31:0] wr_data;
    wire [3:0] wr_strb;
    wire boot_sync;
    reg [15:0] rd_val;
    reg rd_hit;
    reg wr_hit;

    reg [2:0] state_ff, nxt_state;
    reg [2:0] op_ff, nxt_op;
    reg phase_ff, nxt_phase;
    reg [15:0] cmd_ff, nxt_cmd;
    reg busy_ff, nxt_busy;
    reg lock_ff, nxt_lock;
    reg err_ff, nxt_err;
    reg seq_ff, nxt_seq;
    reg [15:0] secl_ff, sech_ff, d0l_ff, d0h_ff, d1l_ff, d1h_ff;
    reg [15:0] adrl_ff, adrh_ff;
    reg go_ff, nxt_go;
    reg pause_request_ff, nxt_pause_request;
    reg resume_ff, nxt_resume;
    reg [7:0] fill_ff, nxt_fill;
    reg [31:0] aaddr_ff;
    reg [63:0] wdata_ff;
    reg trap_ff;

    fwc_axil #(.AW(AW)) u_bus (
        .clk(CLOCK), .rst(SYS_RST),
        .awaddr(S_AXI_AWADDR), .awvalid(S_AXI_AWVALID),
        .awready(S_AXI_AWREADY), .wdata(S_AXI_WDATA),
        .wstrb(S_AXI_WSTRB), .wvalid(S_AXI_WVALID),
        .wready(S_AXI_WREADY), .bresp(S_AXI_BRESP),
        .bvalid(S_AXI_BVALID), .bready(S_AXI_BREADY),
        .araddr(S_AXI_ARADDR), .arvalid(S_AXI_ARVALID),
        .arready(S_AXI_ARREADY), .rdata(S_AXI_RDATA),
        .rresp(S_AXI_RRESP), .rvalid(S_AXI_RVALID),
        .rready(S_AXI_RREADY),
        .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data),
        .wr_strb(wr_strb), .wr_hit(wr_hit),
        .rd_stb(rd_stb), .rd_addr(rd_addr), .rd_data(rd_val),
        .rd_hit(rd_hit)
    );

    fwc_sync #(.W(1)) u_boot (
        .clk(CLOCK), .rst(SYS_RST), .d(BOOT_MODE), .q(boot_sync)
    );

    wire [19:0] wr_idx = wr_addr[AW-1:2];
    wire [19:0] rd_idx = rd_addr[AW-1:2];
    wire [15:0] lane = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
    wire [15:0] wv = (cmd_ff & ~lane) | (wr_data[15:0] & lane);
    wire [31:0] tgt = {adrh_ff, adrl_ff};
    // lock only lets the pause bit and the status word through
    wire reg_wr = wr_stb && !lock_ff;
    wire cmd_wr = wr_stb && (wr_idx == `FWC_IDX_CMDH);
    // a write of zero to start is simply not a request
    wire go_req = cmd_wr && !lock_ff && wv[`FWC_START_BIT];
    wire fault = err_ff || seq_ff;
    wire in_test = (tgt >= TEST_LO) && (tgt <= TEST_HI);
    wire prot_ok = (tgt >= `FWC_PROT_LO) && (tgt <= `FWC_PROT_HI);
    wire pick_prog = wv[`FWC_SWP_BIT] || wv[`FWC_DWP_BIT];
    wire [2:0] prog_op = wv[`FWC_DWP_BIT] ? `FWC_OP_DWP : `FWC_OP_SWP;

    // address decode, unmapped answers slverr
    always @* begin
        wr_hit = 1'b1;
        if (wr_idx == `FWC_IDX_STAT || wr_idx == `FWC_IDX_CMDH) begin
            wr_hit = 1'b1;
        end else if (wr_idx >= `FWC_IDX_SECL &&
                     wr_idx <= `FWC_IDX_FAULT && !wr_idx[0]) begin
            wr_hit = 1'b1;
        end else begin
            wr_hit = 1'b0;
        end
    end

    always @* begin
        rd_hit = 1'b1;
        rd_val = `FWC_RESET_16;
        if (rd_idx == `FWC_IDX_STAT) begin
            rd_val[`FWC_LOCK_BIT] = lock_ff;
            rd_val[`FWC_BUSY_BIT] = busy_ff;
        end else if (lock_ff) begin
            rd_val = `FWC_INVALID_DATA;
            rd_hit = (rd_idx >= `FWC_IDX_CMDH) &&
                     (rd_idx <= `FWC_IDX_FAULT) && !rd_idx[0];
        end else if (rd_idx == `FWC_IDX_CMDH) begin
            rd_val = cmd_ff;
        end else if (rd_idx == `FWC_IDX_SECL) begin
            rd_val = secl_ff;
        end else if (rd_idx == `FWC_IDX_SECH) begin
            rd_val = sech_ff;
        end else if (rd_idx == `FWC_IDX_D0L) begin
            rd_val = d0l_ff;
        end else if (rd_idx == `FWC_IDX_D0H) begin
            rd_val = d0h_ff;
        end else if (rd_idx == `FWC_IDX_D1L) begin
            rd_val = d1l_ff;
        end else if (rd_idx == `FWC_IDX_D1H) begin
            rd_val = d1h_ff;
        end else if (rd_idx == `FWC_IDX_ADRL) begin
            rd_val = adrl_ff;
        end else if (rd_idx == `FWC_IDX_ADRH) begin
            rd_val = adrh_ff;
        end else if (rd_idx == `FWC_IDX_FAULT) begin
            rd_val[`FWC_ERR_BIT] = err_ff;
            rd_val[`FWC_SEQ_BIT] = seq_ff;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // select bit of an operation, for self-clearing
    function [15:0] sel_mask;
        input [2:0] op;
        begin
            sel_mask = 16'h0000;
            case (op)
                `FWC_OP_SWP: sel_mask[`FWC_SWP_BIT] = 1'b1;
                `FWC_OP_DWP: sel_mask[`FWC_DWP_BIT] = 1'b1;
                `FWC_OP_WIPE: sel_mask[`FWC_WIPE_BIT] = 1'b1;
                `FWC_OP_PROT: sel_mask[`FWC_PROT_BIT] = 1'b1;
                default: sel_mask = 16'h0000;
            endcase
        end
    endfunction

    always @* begin
        nxt_state = state_ff;
        nxt_op = op_ff;
        nxt_phase = phase_ff;
        nxt_cmd = cmd_ff;
        nxt_busy = busy_ff;
        nxt_lock = lock_ff;
        nxt_err = err_ff;
        nxt_seq = seq_ff;
        nxt_go = 1'b0;
        nxt_pause_request = 1'b0;
        nxt_resume = 1'b0;
        nxt_fill = fill_ff;
        // start bit never taken from software
        if (cmd_wr && !lock_ff) begin
            nxt_cmd = (wv & `FWC_CMD_MASK) & ~(16'h0001 << `FWC_START_BIT);
            nxt_cmd[`FWC_START_BIT] = cmd_ff[`FWC_START_BIT];
        end else if (cmd_wr) begin
            nxt_cmd[`FWC_PAUSE_BIT] = wv[`FWC_PAUSE_BIT];
        end
        if (reg_wr && wr_idx == `FWC_IDX_FAULT) begin
            nxt_err = wr_data[`FWC_ERR_BIT];
            nxt_seq = wr_data[`FWC_SEQ_BIT];
        end
        case (state_ff)
            ST_IDLE: begin
                if (go_req && !fault && !wv[`FWC_PAUSE_BIT]) begin
                    if (wv[`FWC_PROT_BIT]) begin
                        nxt_op = `FWC_OP_PROT;
                    end else if (wv[`FWC_WIPE_BIT]) begin
                        nxt_op = `FWC_OP_WIPE;
                    end else if (pick_prog) begin
                        nxt_op = prog_op;
                    end else begin
                        nxt_op = `FWC_OP_NONE;
                    end
                    if (wv[`FWC_PROT_BIT] && !prot_ok) begin
                        nxt_seq = 1'b1;
                        nxt_err = 1'b1;
                    end else if (!wv[`FWC_PROT_BIT] && !wv[`FWC_WIPE_BIT]
                                 && pick_prog && in_test) begin
                        nxt_seq = 1'b1;
                        nxt_err = 1'b1;
                    end else if (nxt_op != `FWC_OP_NONE) begin
                        nxt_cmd[`FWC_START_BIT] = 1'b1;
                        nxt_busy = 1'b1;
                        nxt_lock = 1'b1;
                        nxt_go = 1'b1;
                        nxt_phase = 1'b0;
                        nxt_fill = `FWC_FILL_PRE;
                        nxt_state = (nxt_op == `FWC_OP_WIPE) ? ST_PRE : ST_RUN;
                    end
                end
            end
            ST_PRE, ST_RUN, ST_NEST: begin
                if (ARR_DONE && state_ff == ST_PRE) begin
                    nxt_phase = 1'b1;
                    nxt_fill = `FWC_FILL_ERASE;
                    nxt_go = 1'b1;
                    nxt_state = ST_RUN;
                end else if (ARR_DONE) begin
                    nxt_cmd = nxt_cmd & ~sel_mask(op_ff);
                    nxt_cmd[`FWC_START_BIT] = 1'b0;
                    nxt_busy = state_ff == ST_NEST ? 1'b0 : 1'b0;
                    nxt_lock = 1'b0;
                    if (state_ff == ST_NEST) begin
                        nxt_op = `FWC_OP_WIPE;
                        nxt_state = ST_ESUSP;
                    end else begin
                        nxt_state = ST_IDLE;
                    end
                end else if (cmd_ff[`FWC_PAUSE_BIT] && state_ff != ST_NEST
                             && op_ff != `FWC_OP_PROT) begin
                    nxt_pause_request = 1'b1;
                    nxt_busy = 1'b0;
                    nxt_lock = 1'b0;
                    nxt_cmd[`FWC_START_BIT] = 1'b0;
                    nxt_state = (op_ff == `FWC_OP_WIPE) ? ST_ESUSP : ST_PSUSP;
                end
            end
            ST_PSUSP: begin
                if (go_req) begin
                    if (!fault && !wv[`FWC_PAUSE_BIT] &&
                        (wv & sel_mask(op_ff)) != 16'h0000) begin
                        nxt_resume = 1'b1;
                        nxt_busy = 1'b1;
                        nxt_lock = 1'b1;
                        nxt_cmd[`FWC_START_BIT] = 1'b1;
                        nxt_state = ST_RUN;
                    end else begin
                        nxt_seq = 1'b1;
                        nxt_err = 1'b1;
                    end
                end
            end
            ST_ESUSP: begin
                // erase resume or a nested program
                if (go_req) begin
                    if (fault || wv[`FWC_PAUSE_BIT] || wv[`FWC_PROT_BIT]) begin
                        nxt_seq = 1'b1;
                        nxt_err = 1'b1;
                    end else if (pick_prog && !in_test) begin
                        nxt_op = prog_op;
                        nxt_go = 1'b1;
                        nxt_busy = 1'b1;
                        nxt_lock = 1'b1;
                        nxt_cmd[`FWC_START_BIT] = 1'b1;
                        nxt_state = ST_NEST;
                    end else if (wv[`FWC_WIPE_BIT] && !pick_prog) begin
                        nxt_resume = 1'b1;
                        nxt_busy = 1'b1;
                        nxt_lock = 1'b1;
                        nxt_cmd[`FWC_START_BIT] = 1'b1;
                        nxt_state = phase_ff ? ST_RUN : ST_PRE;
                    end else begin
                        nxt_seq = 1'b1;
                        nxt_err = 1'b1;
                    end
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge CLOCK) begin
        if (SYS_RST) begin
            state_ff <= ST_IDLE;
            op_ff <= `FWC_OP_NONE;
            phase_ff <= 1'b0;
            cmd_ff <= `FWC_RESET_16;
            busy_ff <= 1'b0;
            lock_ff <= 1'b0;
            err_ff <= 1'b0;
            seq_ff <= 1'b0;
            secl_ff <= `FWC_RESET_16;
            sech_ff <= `FWC_RESET_16;
            d0l_ff <= `FWC_RESET_16;
            d0h_ff <= `FWC_RESET_16;
            d1l_ff <= `FWC_RESET_16;
            d1h_ff <= `FWC_RESET_16;
            adrl_ff <= `FWC_RESET_16;
            adrh_ff <= `FWC_RESET_16;
            go_ff <= 1'b0;
            pause_request_ff <= 1'b0;
            resume_ff <= 1'b0;
            fill_ff <= `FWC_FILL_PRE;
            aaddr_ff <= 32'h00000000;
            wdata_ff <= 64'h0000000000000000;
            trap_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            op_ff <= nxt_op;
            phase_ff <= nxt_phase;
            cmd_ff <= nxt_cmd;
            busy_ff <= nxt_busy;
            lock_ff <= nxt_lock;
            err_ff <= nxt_err;
            seq_ff <= nxt_seq;
            go_ff <= nxt_go;
            pause_request_ff <= nxt_pause_request;
            resume_ff <= nxt_resume;
            fill_ff <= nxt_fill;
            if (reg_wr) begin
                if (wr_idx == `FWC_IDX_SECL) secl_ff <= wr_data[15:0];
                if (wr_idx == `FWC_IDX_SECH) sech_ff <= wr_data[15:0];
                if (wr_idx == `FWC_IDX_D0L) d0l_ff <= wr_data[15:0];
                if (wr_idx == `FWC_IDX_D0H) d0h_ff <= wr_data[15:0];
                if (wr_idx == `FWC_IDX_D1L) d1l_ff <= wr_data[15:0];
                if (wr_idx == `FWC_IDX_D1H) d1h_ff <= wr_data[15:0];
                if (wr_idx == `FWC_IDX_ADRL) adrl_ff <= wr_data[15:0];
                if (wr_idx == `FWC_IDX_ADRH) adrh_ff <= wr_data[15:0];
            end
            if (nxt_go && state_ff != ST_PRE) begin
                aaddr_ff <= tgt;
                wdata_ff <= {d1h_ff, d1l_ff, d0h_ff, d0l_ff} & ARR_OLD;
            end
            trap_ff <= (BANK_RD && busy_ff) ||
                       (rd_stb && lock_ff && rd_idx != `FWC_IDX_STAT);
        end
    end

    assign ARR_GO = go_ff;
    assign ARR_SUSPEND = pause_request_ff;
    assign ARR_RESUME = resume_ff;
    assign ARR_OP = op_ff;
    assign ARR_ADDR = aaddr_ff;
    assign ARR_WDATA = wdata_ff;
    assign ARR_FILL = fill_ff;
    assign ARR_SECTORS = {sech_ff, secl_ff};
    assign BANK_TRAP = trap_ff;
    assign TRAP_NUM = `FWC_TRAP_CODE;
    assign BANK_WR_EN = !busy_ff;
    // test sector shown in bootstrap only
    assign TEST_SECTOR_VISIBLE = boot_sync;
endmodule
`default_nettype wire

// ===== verification/fwc_top_props.sv
// checker of the flash write control top
`timescale 1ns/1ns
`default_nettype none
module fwc_top_props (
    // clock and reset
    input wire logic CLOCK,
    input wire logic SYS_RST,
    // array engine
    input wire logic ARR_GO,
    input wire logic ARR_SUSPEND,
    input wire logic ARR_RESUME,
    input wire logic [2:0] ARR_OP,
    input wire logic [7:0] ARR_FILL,
    input wire logic ARR_DONE,
    // bank access
    input wire logic BANK_RD,
    input wire logic BANK_TRAP,
    input wire logic [7:0] TRAP_NUM,
    input wire logic BANK_WR_EN
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);
    wire busy = !BANK_WR_EN;
    // wipe done while busy; the fill tells the phase apart
    wire wdone = ARR_DONE && busy && ARR_OP == 3'h3;
    property p_go; ARR_GO |-> busy; endproperty
    a_go: assert property (p_go) else $error("go while idle");
    property p_pause_request; ARR_SUSPEND |-> !busy && !ARR_GO; endproperty
    a_pause_request: assert property (p_pause_request) else $error("busy in pause");
    property p_res; ARR_RESUME |-> busy; endproperty
    a_res: assert property (p_res) else $error("resume idle");
    property p_trap; BANK_RD && busy |=> BANK_TRAP; endproperty
    a_trap: assert property (p_trap) else $error("no trap");
    property p_num; BANK_TRAP |-> TRAP_NUM == 8'h9B; endproperty
    a_num: assert property (p_num) else $error("trap number");
    property p_end; ARR_DONE && busy && ARR_OP != 3'h3 |=> !busy; endproperty
    a_end: assert property (p_end) else $error("busy after end");
    property p_ph2; wdone && ARR_FILL == 8'h00 |=> ARR_GO && ARR_FILL == 8'hFF;
    endproperty
    a_ph2: assert property (p_ph2) else $error("no erase phase");
    property p_wend; wdone && ARR_FILL == 8'hFF |=> !busy; endproperty
    a_wend: assert property (p_wend) else $error("wipe not ended");
    c_pause_request: cover property (ARR_SUSPEND);
    c_res: cover property (ARR_RESUME);
    c_trap: cover property (BANK_TRAP);
endmodule
bind fwc_top fwc_top_props u_props (.CLOCK, .SYS_RST, .ARR_GO, .ARR_SUSPEND,
    .ARR_RESUME, .ARR_OP, .ARR_FILL, .ARR_DONE, .BANK_RD, .BANK_TRAP,
    .TRAP_NUM, .BANK_WR_EN);
`default_nettype wire

// ===== verification/tb_flash_write_op_control.sv
// self-checking bench of the flash write control top
`timescale 1ns/1ns
`default_nettype none
`include "fwc_regs.vh"
module tb_flash_write_op_control;
    localparam [19:0] CMD = `FWC_IDX_CMDH;
    logic clock, sys_rst, awv, wv, br, arv, rr, arr_done, ok;
    logic awrdy, wrdy, bv, arrdy, rv, arr_go, wr_en, arr_sus, arr_res;
    logic boot, vis;
    logic [21:0] aw, ar;
    logic [31:0] wd, rdata, rdat;
    logic [1:0] rresp, rrsp, bresp, wrsp;
    logic [2:0] arr_op, g_op;
    logic [7:0] arr_fill, g_fill;
    logic [63:0] arr_wdata;
    logic [31:0] arr_addr, secs;
    integer errors, num_checks, gos, g, n, ress, suss, r, s;
    // bank reads ride on the read address valid
    fwc_top uut (.CLOCK(clock), .SYS_RST(sys_rst), .S_AXI_AWADDR(aw),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wd),
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
        .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
        .S_AXI_RREADY(rr), .ARR_GO(arr_go), .ARR_SUSPEND(arr_sus),
        .ARR_RESUME(arr_res), .ARR_OP(arr_op), .ARR_ADDR(arr_addr),
        .ARR_WDATA(arr_wdata), .ARR_FILL(arr_fill), .ARR_SECTORS(secs),
        .ARR_OLD(64'h0F0FFFFFFFFF0F0F), .ARR_DONE(arr_done),
        .BOOT_MODE(boot), .BANK_RD(arv), .BANK_TRAP(), .TRAP_NUM(),
        .BANK_WR_EN(wr_en), .TEST_SECTOR_VISIBLE(vis));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // the go pulse comes and goes with the write answer, so log it here
    always @(posedge clock) begin
        if (arr_go === 1'b1) begin
            gos <= gos + 1;
            g_op <= arr_op;
            g_fill <= arr_fill;
        end
        if (arr_sus === 1'b1) suss <= suss + 1;
        if (arr_res === 1'b1) ress <= ress + 1;
    end
    task chk(input string nm, input [31:0] s, input [31:0] e);
        num_checks = num_checks + 1;
        if (s !== e) begin
            errors = errors + 1;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask
    task summarize;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task tmo;
        if (!ok) begin
            errors = errors + 1;
            summarize;
        end
    endtask
    task wr(input [19:0] i, input [15:0] d);
        ok = 1'b0;
        @(posedge clock);
        aw <= {i, 2'b00};
        wd <= {16'h0000, d};
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        for (n = 0; n < 50 && !ok; n = n + 1) begin
            @(posedge clock);
            if (awrdy === 1'b1) awv <= 1'b0;
            if (wrdy === 1'b1) wv <= 1'b0;
            ok = bv === 1'b1;
        end
        wrsp = bresp;
        br <= 1'b0;
        tmo;
    endtask
    task rd(input [19:0] i);
        ok = 1'b0;
        @(posedge clock);
        ar <= {i, 2'b00};
        arv <= 1'b1;
        rr <= 1'b1;
        for (n = 0; n < 50 && !ok; n = n + 1) begin
            @(posedge clock);
            if (arrdy === 1'b1) arv <= 1'b0;
            ok = rv === 1'b1;
        end
        rr <= 1'b0;
        rdat = rdata;
        rrsp = rresp;
        tmo;
    endtask
    task fin;
        @(posedge clock);
        arr_done <= 1'b1;
        @(posedge clock);
        arr_done <= 1'b0;
        repeat (3) @(posedge clock);
    endtask
    // a resume pulses the resume line, not go; the op level stays put
    task run(input [15:0] c, input [2:0] op, input rs);
        g = gos;
        r = ress;
        wr(CMD, c);
        rd(CMD);
        chk("lock", rdat, 32'h0000FFFF);
        chk("go", gos - g, !rs);
        chk("resume", ress - r, rs);
        chk("op", arr_op, op);
        fin;
        rd(CMD);
        chk("cmd", rdat, 0);
    endtask
    initial begin
        {errors, num_checks, gos, ress, suss} = 0;
        {awv, wv, br, arv, rr, arr_done, boot} = 0;
        {aw, ar, wd} = 0;
        sys_rst = 1'b1;
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        rd(CMD);
        chk("reset", rdat, 0);
        chk("vis0", vis, 0);
        rd(20'h80001);
        chk("unmapped", rrsp, 2'h2);
        wr(20'h80001, 16'h0000);
        chk("wunmap", wrsp, 2'h2);
        wr(`FWC_IDX_ADRL, 16'h4000);
        wr(`FWC_IDX_D0L, 16'h1234);
        wr(`FWC_IDX_D0H, 16'hFFFF);
        wr(`FWC_IDX_D1L, 16'hF0F0);
        run(16'hA000, 3'h1, 1'b0);
        chk("wdlo", arr_wdata[31:0], 32'hFFFF0204);
        chk("waddr", arr_addr, 32'h00004000);
        run(16'h9000, 3'h2, 1'b0);
        chk("wdhi", arr_wdata[63:32], 32'h0000F0F0);
        wr(`FWC_IDX_SECL, 16'h0001);
        chk("sec", secs, 32'h00000001);
        g = gos;
        wr(CMD, 16'h8800);
        chk("pre", arr_fill, 8'h00);
        fin;
        chk("fill", g_fill, 8'hFF);
        chk("phases", gos - g, 2);
        fin;
        rd(CMD);
        chk("wipe", rdat, 0);
        wr(CMD, 16'hA000);
        s = suss;
        wr(CMD, 16'h6000);
        rd(CMD);
        chk("pause_request", rdat, 32'h00006000);
        chk("wren", wr_en, 1);
        chk("pause", suss - s, 1);
        wr(CMD, 16'h8800);
        rd(`FWC_IDX_FAULT);
        chk("psrej", rdat, 3);
        wr(`FWC_IDX_FAULT, 16'h0000);
        run(16'hA000, 3'h1, 1'b1);
        wr(CMD, 16'h8800);
        wr(CMD, 16'h4800);
        g = gos;
        wr(CMD, 16'hA000);
        fin;
        chk("nest", gos - g, 1);
        chk("nestop", g_op, 3'h1);
        r = ress;
        wr(CMD, 16'h8800);
        fin;
        fin;
        rd(CMD);
        chk("eres", ress - r, 1);
        chk("wipe2", rdat, 0);
        wr(CMD, 16'h8100);
        rd(`FWC_IDX_FAULT);
        chk("seq", rdat[1], 1);
        g = gos;
        wr(CMD, 16'hA000);
        rd(CMD);
        chk("refuse", rdat, 32'h00002000);
        chk("nogo", gos - g, 0);
        wr(`FWC_IDX_FAULT, 16'h0000);
        wr(`FWC_IDX_ADRH, 16'h0008);
        wr(`FWC_IDX_ADRL, 16'hDFB0);
        run(16'h8100, 3'h4, 1'b0);
        chk("paddr", arr_addr, 32'h0008DFB0);
        wr(`FWC_IDX_ADRL, 16'h0000);
        wr(`FWC_IDX_ADRH, 16'h0000);
        g = gos;
        wr(CMD, 16'hA000);
        rd(`FWC_IDX_FAULT);
        chk("test", rdat, 3);
        chk("tgo", gos - g, 0);
        boot <= 1'b1;
        repeat (3) @(posedge clock);
        chk("vis1", vis, 1);
        summarize;
    end
endmodule
`default_nettype wire
